// *** asf_pkg.sv ***
// Package for the ALU status flag block: flag positions, operation codes, carriers.
// Assumes the core decodes instructions and presents one operation per cycle.
package asf_pkg;

    localparam int FLAG_NEG    = 4;
    localparam int FLAG_WRAP   = 3;
    localparam int FLAG_ZERO   = 2;
    localparam int FLAG_NIBBLE = 1;
    localparam int FLAG_CARRY  = 0;
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] FLAGS_IMPL    = 8'h1f;

    // Data addressing modes
    typedef enum logic [2:0] {
        ASF_AM_INHERENT,
        ASF_AM_LITERAL,
        ASF_AM_DIRECT,
        ASF_AM_INDIRECT,
        ASF_AM_INDEXED
    } asf_amode_e;

    // Operation classes seen by the flag logic
    typedef enum logic [3:0] {
        ASF_OP_NONE,
        ASF_OP_ADD,
        ASF_OP_ADDC,
        ASF_OP_SUB,
        ASF_OP_SUBB,
        ASF_OP_RRC,
        ASF_OP_RLC,
        ASF_OP_LOGIC,
        ASF_OP_CLEAR,
        ASF_OP_MOVE,
        ASF_OP_BITSET,
        ASF_OP_BITCLR,
        ASF_OP_SWAP
    } asf_op_e;

    typedef struct packed {
        logic       valid;
        asf_op_e    op;
        logic [7:0] a;
        logic [7:0] b;
        logic [2:0] bit_sel;
        logic       dest_flags;
        asf_amode_e amode;
    } asf_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       write;
        logic       mode_err;
    } asf_rsp_s;

    typedef struct packed {
        logic [4:0] flags;
        asf_rsp_s   rsp;
    } asf_state_s;

endpackage : asf_pkg

// *** asf_status_flags.sv ***
// ALU status flag datapath and flag register of an 8-bit core.
// Assumes a synchronous core driving one request per cycle on clk_sys.
// How it works
// - A flag-altering op aimed at the flag register drops its result; only flags update.
// - Clearing the flag register sets only the zero flag, leaving the rest (000u u1uu).
// - The flag register can be read, but only move, bit set, bit clear and swap write it like other registers.
// - Subtraction adds the two's complement, so carry and nibble carry mean not-borrow.
// - Negative flag bit 4 copies result bit 7.
// - Signed wrap flag bit 3 is set when the signed result overflows 7-bit magnitude.
// - Zero flag bit 2 is set when the result is zero.
// - Nibble carry flag bit 1 takes the carry out of result bit 3 for add and subtract.
// - Carry flag bit 0 takes the carry out of result bit 7 for add and subtract.
// - Rotates load the nibble carry from source bit 4 or bit 3.
// - Rotates load carry from source bit 7 or bit 0 depending on direction.
// - Inherent, literal, direct and indirect addressing are always accepted.
// - Indexed literal-offset mode is accepted only with extended_instruction_enable.
`timescale 1ns/1ps
module asf_status_flags
    import asf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Configuration
    input  wire logic       extended_instruction_enable,
    // Operation request
    input  wire asf_req_s   req,
    // Result and flag register
    output asf_rsp_s        rsp,
    output logic [7:0]      alu_flags
);

    // Registered state: flag bits plus the answer to the last request
    asf_state_s  st_q;
    asf_state_s  st_d;

    // Decode and datapath helpers
    logic [10:0] sum;
    logic        arith;
    logic        subtract;
    logic        carry_in;
    logic        mode_ok;
    logic        sets_nz;
    logic [7:0]  rot_val;
    logic [1:0]  nz_val;

    // Zero test shared by every op that sets the zero flag from its result
    function automatic logic is_zero(input logic [7:0] v);
        return (v == 8'h00);
    endfunction : is_zero

    // One-hot mask for the bit set and bit clear ops
    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        logic [7:0] m;
        m = 8'h01 << sel;
        return m;
    endfunction : bit_mask

    // Ops that never touch an arithmetic flag; the only safe writers of the flag register
    function automatic logic flag_neutral(input asf_op_e o);
        return (o inside {ASF_OP_MOVE, ASF_OP_BITSET, ASF_OP_BITCLR, ASF_OP_SWAP});
    endfunction : flag_neutral

    // Rotate through carry: the old carry enters at the far end
    function automatic logic [7:0] rot8(input logic [7:0] v,
                                        input logic       cin,
                                        input logic       to_left);
        logic [7:0] r;
        if (to_left) begin
            r = {v[6:0], cin};
        end else begin
            r = {cin, v[7:1]};
        end
        return r;
    endfunction : rot8

    // 8-bit add with carry in, giving {wrap, nibble carry, carry, result}
    function automatic logic [10:0] add8(input logic [7:0] x,
                                         input logic [7:0] y,
                                         input logic       cin);
        logic [4:0] lo;
        logic [8:0] s;
        logic       wrap;
        lo   = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
        s    = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        // Equal operand signs but a different result sign
        wrap = (x[7] == y[7]) && (s[7] != x[7]);
        return {wrap, lo[4], s[8], s[7:0]};
    endfunction : add8

    // Negative and zero both follow the final result
    function automatic logic [1:0] nz_flags(input logic [7:0] v);
        logic [1:0] f;
        f = {v[7], is_zero(v)};
        return f;
    endfunction : nz_flags

    // One pass per cycle: answer and flags settle together for the next edge
    always_comb begin
        st_d              = st_q;
        st_d.rsp.valid    = 1'b0;
        st_d.rsp.write    = 1'b0;
        st_d.rsp.mode_err = 1'b0;
        sum               = 11'h000;
        arith             = 1'b0;
        subtract          = 1'b0;
        carry_in          = 1'b0;
        sets_nz           = 1'b0;
        rot_val           = 8'h00;
        nz_val            = 2'b00;
        // Indexed literal-offset exists only with the extended set on
        mode_ok = (req.amode != ASF_AM_INDEXED)
                  || extended_instruction_enable;
        if (req.valid) begin
            st_d.rsp.valid    = 1'b1;
            // Refused requests still answer, flagged and unwritten
            st_d.rsp.mode_err = !mode_ok;
        end
        if (req.valid && mode_ok) begin
            st_d.rsp.write = 1'b1;
            // Result and op-specific flags
            unique case (req.op)
                ASF_OP_ADD: begin
                    arith    = 1'b1;
                    carry_in = 1'b0;
                end
                ASF_OP_ADDC: begin
                    arith    = 1'b1;
                    carry_in = st_q.flags[FLAG_CARRY];
                end
                // Two's complement of b: invert and add one
                ASF_OP_SUB: begin
                    arith    = 1'b1;
                    subtract = 1'b1;
                    carry_in = 1'b1;
                end
                // Carry reads as not-borrow, so it is the +1 itself
                ASF_OP_SUBB: begin
                    arith    = 1'b1;
                    subtract = 1'b1;
                    carry_in = st_q.flags[FLAG_CARRY];
                end
                ASF_OP_RRC: begin
                    rot_val                 = rot8(req.a, st_q.flags[FLAG_CARRY], 1'b0);
                    st_d.rsp.data           = rot_val;
                    sets_nz                 = 1'b1;
                    st_d.flags[FLAG_CARRY]  = req.a[0];
                    st_d.flags[FLAG_NIBBLE] = req.a[4];
                end
                ASF_OP_RLC: begin
                    rot_val                 = rot8(req.a, st_q.flags[FLAG_CARRY], 1'b1);
                    st_d.rsp.data           = rot_val;
                    sets_nz                 = 1'b1;
                    st_d.flags[FLAG_CARRY]  = req.a[7];
                    st_d.flags[FLAG_NIBBLE] = req.a[3];
                end
                // Logic results arrive on b; only zero and negative follow them
                ASF_OP_LOGIC: begin
                    st_d.rsp.data = req.b;
                    sets_nz       = 1'b1;
                end
                ASF_OP_CLEAR: begin
                    st_d.rsp.data         = 8'h00;
                    // Negative is left alone, hence 000u u1uu on the flag register
                    st_d.flags[FLAG_ZERO] = 1'b1;
                end
                // Flag-neutral ops
                ASF_OP_MOVE: begin
                    st_d.rsp.data = req.b;
                end
                ASF_OP_BITSET: begin
                    st_d.rsp.data = req.a | bit_mask(req.bit_sel);
                end
                ASF_OP_BITCLR: begin
                    st_d.rsp.data = req.a & ~bit_mask(req.bit_sel);
                end
                ASF_OP_SWAP: begin
                    st_d.rsp.data = {req.a[3:0], req.a[7:4]};
                end
                // No-op and unused codes change nothing
                default: begin
                    st_d.rsp.write = 1'b0;
                end
            endcase

            if (arith) begin
                sum                     = add8(req.a, subtract ? ~req.b : req.b, carry_in);
                st_d.rsp.data           = sum[7:0];
                sets_nz                 = 1'b1;
                st_d.flags[FLAG_CARRY]  = sum[8];
                st_d.flags[FLAG_NIBBLE] = sum[9];
                st_d.flags[FLAG_WRAP]   = sum[10];
            end
            // Signed wrap is left alone by rotates and logic
            if (sets_nz) begin
                nz_val                = nz_flags(st_d.rsp.data);
                st_d.flags[FLAG_NEG]  = nz_val[1];
                st_d.flags[FLAG_ZERO] = nz_val[0];
            end

            if (req.dest_flags) begin
                if (flag_neutral(req.op)) begin
                    // Plain write of the implemented flag bits
                    st_d.flags = st_d.rsp.data[4:0];
                end else begin
                    // Flag-altering op: the computed value is dropped
                    st_d.rsp.write = 1'b0;
                end
            end
        end
    end

    // Flags start cleared; their power-on value is not otherwise defined
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= '{flags: FLAGS_RESET[4:0], rsp: '0};
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from the state flops; bits 7:5 are unimplemented and read 0
    assign rsp       = st_q.rsp;
    assign alu_flags = {3'b000, st_q.flags};

endmodule : asf_status_flags

// *** asf_status_flags_props.sv ***
// Checker for the status flag block: flag relations seen at its ports.
// Assumes one clk_sys domain, rst active high.
`timescale 1ns/1ps
module asf_status_flags_props
    import asf_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst,
    // Watched ports
    input wire logic       extended_instruction_enable,
    input wire asf_req_s   req,
    input wire asf_rsp_s   rsp,
    input wire logic [7:0] alu_flags
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic       plain_op;
    logic [8:0] sum9;
    logic       add_c, add_dc, add_ov;
    logic [1:0] rr_bits, rl_bits;
    assign plain_op = req.valid && !req.dest_flags && req.amode != ASF_AM_INDEXED;
    assign sum9     = {1'b0, req.a} + {1'b0, req.b};
    assign add_c    = sum9[8];
    assign add_dc   = ({1'b0, req.a[3:0]} + {1'b0, req.b[3:0]}) > 5'h0f;
    assign add_ov   = (req.a[7] == req.b[7]) && (sum9[7] != req.a[7]);
    assign rr_bits  = {req.a[4], req.a[0]};
    assign rl_bits  = {req.a[3], req.a[7]};
    answer_pulse_a: assert property (rsp.valid == $past(req.valid))
        else $error("answer pulse does not follow request");
    add_carry_a: assert property (plain_op && req.op == ASF_OP_ADD |=>
        alu_flags[1:0] == {$past(add_dc), $past(add_c)}) else $error("add carry wrong");
    add_wrap_a: assert property (plain_op && req.op == ASF_OP_ADD |=>
        alu_flags[FLAG_WRAP] == $past(add_ov)) else $error("add wrap flag wrong");
    zero_neg_a: assert property (
        plain_op && req.op inside {ASF_OP_ADD, ASF_OP_SUB} |=>
        alu_flags[4] == rsp.data[7] && alu_flags[2] == (rsp.data == 8'h00))
        else $error("zero or negative flag wrong");
    sub_borrow_a: assert property (plain_op && req.op == ASF_OP_SUB |=>
        alu_flags[FLAG_CARRY] == ($past(req.a) >= $past(req.b))) else $error("borrow wrong");
    rot_right_a: assert property (plain_op && req.op == ASF_OP_RRC |=>
        alu_flags[1:0] == $past(rr_bits)) else $error("right rotate carries wrong");
    rot_left_a: assert property (plain_op && req.op == ASF_OP_RLC |=>
        alu_flags[1:0] == $past(rl_bits)) else $error("left rotate carries wrong");
    index_refuse_a: assert property (req.valid && req.amode == ASF_AM_INDEXED
        && !extended_instruction_enable |=> rsp.mode_err && !rsp.write && $stable(alu_flags))
        else $error("indexed mode not refused");
    clear_dest_a: assert property (
        req.valid && req.dest_flags && req.op == ASF_OP_CLEAR
        && req.amode != ASF_AM_INDEXED |=> !rsp.write
        && alu_flags == ($past(alu_flags) | 8'h04))
        else $error("flag clear wrong");
    flags_hold_a: assert property (!req.valid |=> $stable(alu_flags))
        else $error("flags moved without an operation");
endmodule : asf_status_flags_props
bind asf_status_flags asf_status_flags_props u_props (.clk_sys, .rst,
    .extended_instruction_enable, .req, .rsp, .alu_flags);

// *** test_asf_status_flags.sv ***
// Testbench for the status flag block: directed flag scenarios.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
module test_asf_status_flags;
    import asf_pkg::*;
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       xen = 1'b0;
    asf_req_s   req = '0;
    asf_rsp_s   rsp;
    logic [7:0] alu_flags;
    int         n_errors = 0;
    int         total_checks = 0;
    always #25 clk_sys = ~clk_sys;
    asf_status_flags uut (.clk_sys, .rst, .extended_instruction_enable(xen), .req, .rsp,
        .alu_flags);
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Answer stands one cycle, so it is judged at the next falling edge
    task automatic op(input asf_op_e o, input logic [7:0] a, input logic [7:0] b,
                      input logic d = 1'b0, input asf_amode_e m = ASF_AM_DIRECT,
                      input logic [2:0] s = 3'h0);
        @(negedge clk_sys);
        req = '{1'b1, o, a, b, s, d, m};
        @(negedge clk_sys);
        req.valid = 1'b0;
    endtask : op
    task automatic t_reset;
        chk("reset flags", FLAGS_RESET, alu_flags);
        chk("reset answer", 8'h00, {5'h0, rsp.valid, rsp.write, rsp.mode_err});
        chk("reset data", 8'h00, rsp.data);
        $display("test reset done");
    endtask : t_reset
    task automatic t_arith;
        op(ASF_OP_ADD, 8'h08, 8'h08);
        chk("add data", 8'h10, rsp.data);
        chk("add flags", 8'h02, alu_flags);
        op(ASF_OP_ADD, 8'h80, 8'h80);
        chk("wrap flags", 8'h0d, alu_flags);
        op(ASF_OP_SUB, 8'h05, 8'h06);
        chk("borrow flags", 8'h10, alu_flags);
        op(ASF_OP_SUB, 8'h07, 8'h03);
        chk("no borrow flags", 8'h03, alu_flags);
        $display("test arith done");
    endtask : t_arith
    task automatic t_rot;
        op(ASF_OP_RRC, 8'h11, 8'h00);
        chk("rrc carries", 8'h03, alu_flags & 8'h03);
        op(ASF_OP_RLC, 8'h08, 8'h00);
        chk("rlc carries", 8'h02, alu_flags & 8'h03);
        $display("test rot done");
    endtask : t_rot
    task automatic t_dest;
        op(ASF_OP_ADD, 8'h08, 8'h08);
        op(ASF_OP_CLEAR, 8'h00, 8'h00, 1'b1);
        chk("clear write", 8'h00, {7'h0, rsp.write});
        chk("clear flags", 8'h06, alu_flags);
        op(ASF_OP_MOVE, 8'h00, 8'h1b, 1'b1);
        chk("move flags", 8'h1b, alu_flags);
        $display("test dest done");
    endtask : t_dest
    task automatic t_mode;
        for (int i = 0; i < 4; i++) begin
            op(ASF_OP_MOVE, 8'h00, 8'h5a, 1'b0, asf_amode_e'(i));
            chk("mode write", 8'h01, {7'h0, rsp.write});
        end
        op(ASF_OP_ADD, 8'h01, 8'h01, 1'b0, ASF_AM_INDEXED);
        chk("refused", 8'h01, {7'h0, rsp.mode_err & ~rsp.write});
        chk("refused flags", 8'h1b, alu_flags);
        xen = 1'b1;
        op(ASF_OP_ADD, 8'h01, 8'h01, 1'b0, ASF_AM_INDEXED);
        chk("indexed data", 8'h02, rsp.data);
        chk("indexed flags", 8'h00, alu_flags);
        $display("test mode done");
    endtask : t_mode
    task automatic t_hold;
        op(ASF_OP_ADD, 8'hff, 8'h01);
        op(ASF_OP_LOGIC, 8'h00, 8'h80);
        chk("logic keeps carries", 8'h13, alu_flags);
        op(ASF_OP_BITSET, 8'h00, 8'h00);
        chk("bitset data", 8'h01, rsp.data);
        chk("bitset keeps flags", 8'h13, alu_flags);
        $display("test hold done");
    endtask : t_hold
    task automatic t_more;
        op(ASF_OP_ADDC, 8'h0f, 8'h00);
        chk("addc data", 8'h10, rsp.data);
        chk("addc flags", 8'h02, alu_flags);
        chk("answer valid", 8'h01, {7'h0, rsp.valid});
        @(negedge clk_sys);
        chk("answer idle", 8'h00, {7'h0, rsp.valid});
        op(ASF_OP_SUBB, 8'h05, 8'h03);
        chk("subb data", 8'h01, rsp.data);
        chk("subb flags", 8'h03, alu_flags);
        op(ASF_OP_RRC, 8'h02, 8'h00);
        chk("rrc data", 8'h81, rsp.data);
        chk("rrc flags", 8'h10, alu_flags);
        op(ASF_OP_RLC, 8'h80, 8'h00);
        chk("rlc data", 8'h00, rsp.data);
        chk("rlc flags", 8'h05, alu_flags);
        op(ASF_OP_SWAP, 8'h3c, 8'h00);
        chk("swap data", 8'hc3, rsp.data);
        op(ASF_OP_BITCLR, 8'hff, 8'h00, 1'b0, ASF_AM_DIRECT, 3'h5);
        chk("bitclr data", 8'hdf, rsp.data);
        chk("neutral flags", 8'h05, alu_flags);
        op(ASF_OP_ADD, 8'h08, 8'h08, 1'b1);
        chk("dest add write", 8'h00, {7'h0, rsp.write});
        chk("dest add flags", 8'h02, alu_flags);
        op(ASF_OP_SWAP, 8'h1c, 8'h00, 1'b1);
        chk("dest swap flags", 8'h01, alu_flags);
        $display("test more done");
    endtask : t_more
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        t_reset;
        t_arith;
        t_rot;
        t_dest;
        t_mode;
        t_hold;
        t_more;
        report_and_stop;
    end
    // Tests need about 58 cycles; over eight times that means a hang
    initial begin
        #(500 * 50);
        n_errors++;
        report_and_stop;
    end
endmodule : test_asf_status_flags
